/* hdl/reassembly_event_pkg.sv */
package reassembly_event_pkg;
    // ======================================================
    // register offsets on the host port (word index)
    localparam logic [3:0] ADDR_MODE_ZERO = 4'h0;
    localparam logic [3:0] ADDR_MODE_ONE = 4'h1;
    localparam logic [3:0] ADDR_EVENT_FLAGS = 4'h2;
    localparam logic [3:0] ADDR_QUEUE_COND = 4'h3;
    localparam logic [3:0] ADDR_EVENT_MASK = 4'h4;

    // ======================================================
    // reset values
    localparam logic [15:0] MODE_ZERO_RST = 16'h0000;
    localparam logic [15:0] MODE_ONE_RST = 16'h0000;
    localparam logic [15:0] EVENT_FLAGS_RST = 16'h0000;
    localparam logic [15:0] EVENT_MASK_RST = 16'hFFFF;
    localparam logic [3:0] ARMED_RST = 4'hF;

    // ======================================================
    // mode register zero fields
    localparam int M0_WR_PROTECT = 0;
    localparam int M0_ON_LINE = 1;
    localparam int M0_UNPROC_OVERWRITE = 2;
    localparam int M0_CONST_RATE_OVERWRITE = 3;

    // mode register one fields
    localparam int M1_EVEN_PARITY = 0;
    localparam int M1_CONG_FORWARD = 1;
    localparam int M1_CONG_CHECK = 2;

    // ======================================================
    // event flag positions
    localparam int EV_UNPROC_ARRIVED = 0;
    localparam int EV_CONST_ARRIVED = 1;
    localparam int EV_DONE_ARRIVED = 2;
    localparam int EV_EXC_ARRIVED = 3;
    localparam int EV_UNPROC_OVERRUN = 4;
    localparam int EV_CONST_OVERRUN = 5;
    localparam int EV_DONE_OVERRUN = 6;
    localparam int EV_EXC_OVERRUN = 7;
    localparam int EV_LITTLE_EXHAUST = 8;
    localparam int EV_BIG_EXHAUST = 9;
    localparam int EV_CM_PARITY = 10;
    localparam int EV_RESERVED = 11;
    localparam int EV_CELL_WRAP = 12;
    localparam int EV_CONST_WRAP = 13;
    localparam int EV_FAULT_WRAP = 14;
    localparam int EV_PKT_WRAP = 15;

    // queue condition register: off-line flag position
    localparam int QC_OFF_LINE = 15;

    // ======================================================
    // on-line control states
    typedef enum logic [2:0] {
        ST_OFFLINE = 3'b001,
        ST_ONLINE = 3'b010,
        ST_DRAIN = 3'b100
    } line_state_t;
endpackage

/* hdl/reassembly_event_status_regs.sv */
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - congestion payload CRC checked only while the check enable bit is 1.
// - congestion cells go to the unprocessed queue only when forwarding on.
// - parity sense 0 odd, 1 even; generated on writes, checked on reads.
// - event flags are sticky; interrupt only for flags with mask bit 0.
// - a masked event still sets its flag but gives no interrupt.
// - reading the event flags returns them and clears them.
// - flags 15..12 set on wrap of the four counters.
// - flag 11 is reserved and always reads zero.
// - control memory parity fault sets flag 10 and aborts the cell.
// - flag 9 and drop when the needed free list is exhausted.
// - flag 8 and drop when a small packet finds both lists empty.
// - flag 7 when an exception cannot be logged, list full.
// - flag 6 and hold the packet while the done list is full.
// - flag 5 when const rate cells drop on a full list.
// - flag 4 when unprocessed cells drop on a full list.
// - flag 3 on exception list empty to busy, rearmed once empty.
// - flag 2 on done list empty to busy, rearmed once empty.
// - flag 1 on const rate list empty to busy, rearmed once empty.
// - flag 0 on unprocessed list empty to busy, rearmed once empty.
// - queue condition register is read-only, live, no interrupts.
// - off-line bit 1 after reset and while off-line, 0 when running.
// - bits 11..0 show full/empty pairs of six queues; 14..12 zero.
// - on-line bit 0 finishes the current cycle, then goes off-line.
// - overwrite bit 0 drops on full; 1 writes regardless of full.
module reassembly_event_status_regs
    import reassembly_event_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output logic o_irq,
    input wire logic i_cycle_busy,
    output logic o_reassembly_run,
    output logic o_ctrl_mem_access_en,
    input wire logic i_drop_packet_count_wrap,
    input wire logic i_fault_count_wrap,
    input wire logic i_drop_const_rate_count_wrap,
    input wire logic i_total_cell_count_wrap,
    input wire logic [15:0] i_cm_wr_data,
    input wire logic [31:0] i_pm_wr_data,
    output logic o_cm_wr_parity,
    output logic o_pm_wr_parity,
    input wire logic i_cm_rd_valid,
    input wire logic i_cm_par_chk_en,
    input wire logic [15:0] i_cm_rd_data,
    input wire logic i_cm_rd_parity,
    output logic o_cell_abort,
    input wire logic i_cell_valid,
    input wire logic i_cell_par_chk_en,
    input wire logic [15:0] i_cell_data,
    input wire logic i_cell_parity,
    output logic o_cell_parity_fault,
    input wire logic i_cong_cell,
    input wire logic i_cong_crc_ok,
    output logic o_cong_crc_fault,
    input wire logic i_raw_cell,
    output logic o_raw_write,
    output logic o_raw_drop,
    input wire logic i_cbr_cell,
    output logic o_cbr_write,
    output logic o_cbr_drop,
    input wire logic i_pkt_arrive,
    input wire logic i_pkt_small,
    output logic o_pkt_drop,
    input wire logic i_exc_report,
    output logic o_exc_write,
    input wire logic i_pkt_finished,
    output logic o_done_write,
    output logic o_pkt_hold,
    input wire logic i_unprocessed_list_at_capacity,
    input wire logic i_unprocessed_list_vacant,
    input wire logic i_const_rate_list_at_capacity,
    input wire logic i_const_rate_list_vacant,
    input wire logic i_exception_list_at_capacity,
    input wire logic i_exception_list_vacant,
    input wire logic i_done_list_at_capacity,
    input wire logic i_done_list_vacant,
    input wire logic i_big_desc_list_at_capacity,
    input wire logic i_big_desc_list_vacant,
    input wire logic i_little_desc_list_at_capacity,
    input wire logic i_little_desc_list_vacant
);
    // ======================================================
    // state
    typedef struct packed {
        logic [15:0] mode_zero;
        logic [15:0] mode_one;
        logic [15:0] flags;
        logic [15:0] mask;
        logic [3:0] armed;
        line_state_t line;
        logic [15:0] rdata;
        logic hold;
        logic abort;
        logic cell_fault;
        logic crc_fault;
        logic raw_write;
        logic raw_drop;
        logic cbr_write;
        logic cbr_drop;
        logic pkt_drop;
        logic exc_write;
        logic done_write;
    } state_t;
    state_t st, next_st;
    logic [15:0] set, qcond;
    logic [3:0] wr_ev, vacant;
    logic even, raw_req, raw_ok, cbr_ok, big_short, little_short;
    logic done_try, cm_fault;
    // ======================================================
    // live queue conditions, assembled each cycle
    // queue pairs
    assign qcond = {st.line == ST_OFFLINE, 3'h0,
        i_unprocessed_list_at_capacity, i_unprocessed_list_vacant,
        i_const_rate_list_at_capacity, i_const_rate_list_vacant,
        i_exception_list_at_capacity, i_exception_list_vacant,
        i_done_list_at_capacity, i_done_list_vacant,
        i_big_desc_list_at_capacity, i_big_desc_list_vacant,
        i_little_desc_list_at_capacity, i_little_desc_list_vacant};
    // parity generation; even sense means the word plus bit has even ones
    // parity sense
    assign even = st.mode_one[M1_EVEN_PARITY];
    assign o_cm_wr_parity = even ? ^i_cm_wr_data : ~^i_cm_wr_data;
    assign o_pm_wr_parity = even ? ^i_pm_wr_data : ~^i_pm_wr_data;
    assign cm_fault = i_cm_rd_valid && i_cm_par_chk_en &&
        ((^{i_cm_rd_data, i_cm_rd_parity}) != ~even);
    // queue admission decisions, combinational so they act this cycle
    // forward congestion
    assign raw_req = i_raw_cell ||
        (i_cong_cell && st.mode_zero[M0_ON_LINE] &&
        st.mode_one[M1_CONG_FORWARD]);
    assign raw_ok = !i_unprocessed_list_at_capacity ||
        st.mode_zero[M0_UNPROC_OVERWRITE];
    assign cbr_ok = !i_const_rate_list_at_capacity ||
        st.mode_zero[M0_CONST_RATE_OVERWRITE];
    assign big_short = i_big_desc_list_vacant &&
        (!i_pkt_small || i_little_desc_list_vacant);
    assign little_short = i_pkt_small && i_big_desc_list_vacant &&
        i_little_desc_list_vacant;
    assign done_try = i_pkt_finished || st.hold;
    // queue writes that may produce an arrival flag
    assign wr_ev = {i_exc_report && !i_exception_list_at_capacity,
        done_try && !i_done_list_at_capacity,
        i_cbr_cell && cbr_ok, raw_req && raw_ok};
    assign vacant = {i_exception_list_vacant, i_done_list_vacant,
        i_const_rate_list_vacant, i_unprocessed_list_vacant};

    // ======================================================
    // event sources gathered into one set vector
    always_comb begin
        set = 16'h0000;
        set[EV_PKT_WRAP] = i_drop_packet_count_wrap;
        set[EV_FAULT_WRAP] = i_fault_count_wrap;
        set[EV_CONST_WRAP] = i_drop_const_rate_count_wrap;
        set[EV_CELL_WRAP] = i_total_cell_count_wrap;
        set[EV_CM_PARITY] = cm_fault;
        set[EV_BIG_EXHAUST] = i_pkt_arrive && big_short;
        set[EV_LITTLE_EXHAUST] = i_pkt_arrive && little_short;
        set[EV_EXC_OVERRUN] = i_exc_report && i_exception_list_at_capacity;
        set[EV_DONE_OVERRUN] = done_try && i_done_list_at_capacity;
        set[EV_CONST_OVERRUN] = i_cbr_cell && !cbr_ok;
        set[EV_UNPROC_OVERRUN] = raw_req && !raw_ok;
        // once per busy spell; the armed bit blocks repeats
        set[EV_EXC_ARRIVED] = wr_ev[3] && vacant[3] && st.armed[3];
        set[EV_DONE_ARRIVED] = wr_ev[2] && vacant[2] && st.armed[2];
        set[EV_CONST_ARRIVED] = wr_ev[1] && vacant[1] && st.armed[1];
        set[EV_UNPROC_ARRIVED] = wr_ev[0] && vacant[0] && st.armed[0];
    end

    // ======================================================
    // next state
    always_comb begin
        next_st = st;
        next_st.rdata = 16'h0000;
        // register writes; flags and queue condition ignore writes
        // read only
        if (i_wr) begin
            case (i_addr)
                ADDR_MODE_ZERO: next_st.mode_zero = i_wdata;
                ADDR_MODE_ONE: next_st.mode_one = i_wdata;
                ADDR_EVENT_MASK: next_st.mask = i_wdata;
                default: next_st.mode_zero = st.mode_zero;
            endcase
        end
        // read data stands one cycle; unmapped addresses read zero
        if (i_rd) begin
            case (i_addr)
                ADDR_MODE_ZERO: next_st.rdata = st.mode_zero;
                ADDR_MODE_ONE: next_st.rdata = st.mode_one;
                ADDR_EVENT_FLAGS: next_st.rdata = st.flags;
                ADDR_QUEUE_COND: next_st.rdata = qcond;
                ADDR_EVENT_MASK: next_st.rdata = st.mask;
                default: next_st.rdata = 16'h0000;
            endcase
        end
        // clear on read; an event in the read cycle survives the clear
        // clear on read
        if (i_rd && i_addr == ADDR_EVENT_FLAGS) begin
            next_st.flags = set;
        end else begin
            next_st.flags = st.flags | set;
        end
        next_st.flags[EV_RESERVED] = 1'b0;
        // rearm each arrival flag while its list sits empty
        for (int i = 0; i < 4; i++) begin
            if (set[i]) begin
                next_st.armed[i] = 1'b0;
            end else if (vacant[i]) begin
                next_st.armed[i] = 1'b1;
            end
        end
        next_st.hold = done_try && i_done_list_at_capacity;
        // registered one-cycle strobes toward the reassembly core
        next_st.abort = cm_fault;
        next_st.cell_fault = i_cell_valid && i_cell_par_chk_en &&
            ((^{i_cell_data, i_cell_parity}) != ~even);
        next_st.crc_fault = i_cong_cell && st.mode_one[M1_CONG_CHECK] &&
            !i_cong_crc_ok;
        next_st.raw_write = raw_req && raw_ok;
        next_st.raw_drop = raw_req && !raw_ok;
        next_st.cbr_write = i_cbr_cell && cbr_ok;
        next_st.cbr_drop = i_cbr_cell && !cbr_ok;
        next_st.pkt_drop = i_pkt_arrive && big_short;
        next_st.exc_write = wr_ev[3];
        next_st.done_write = wr_ev[2];
        // graceful off-line: the running cycle may finish first
        // graceful stop
        case (st.line)
            ST_OFFLINE: begin
                if (st.mode_zero[M0_ON_LINE]) begin
                    next_st.line = ST_ONLINE;
                end
            end
            ST_ONLINE: begin
                if (!st.mode_zero[M0_ON_LINE]) begin
                    next_st.line = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!i_cycle_busy) begin
                    next_st.line = ST_OFFLINE;
                end
            end
            default: next_st.line = ST_OFFLINE;
        endcase
    end
    // ======================================================
    // state register, synchronous reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st <= '{mode_zero: MODE_ZERO_RST, mode_one: MODE_ONE_RST,
                flags: EVENT_FLAGS_RST, mask: EVENT_MASK_RST,
                armed: ARMED_RST, line: ST_OFFLINE, default: '0};
        end else begin
            st <= next_st;
        end
    end

    // ======================================================
    // outputs
    // unmasked flags
    assign o_irq = |(st.flags & ~st.mask);
    assign o_rdata = st.rdata;
    assign o_reassembly_run = st.line == ST_ONLINE;
    assign o_ctrl_mem_access_en = st.line != ST_OFFLINE;
    assign o_pkt_hold = st.hold;
    assign o_cell_abort = st.abort;
    assign o_cell_parity_fault = st.cell_fault;
    assign o_cong_crc_fault = st.crc_fault;
    assign o_raw_write = st.raw_write;
    assign o_raw_drop = st.raw_drop;
    assign o_cbr_write = st.cbr_write;
    assign o_cbr_drop = st.cbr_drop;
    assign o_pkt_drop = st.pkt_drop;
    assign o_exc_write = st.exc_write;
    assign o_done_write = st.done_write;
    // ======================================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    crc_check_off_a: assert property (
        i_cong_cell && !st.mode_one[M1_CONG_CHECK] |=> !o_cong_crc_fault)
        else $error("crc fault while check disabled");
    crc_check_on_a: assert property (
        i_cong_cell && !i_cong_crc_ok && st.mode_one[M1_CONG_CHECK]
        |=> o_cong_crc_fault) else $error("crc fault missed");
    cong_forward_a: assert property (
        i_cong_cell && st.mode_zero[M0_ON_LINE] &&
        st.mode_one[M1_CONG_FORWARD] |=> o_raw_write || o_raw_drop)
        else $error("congestion cell not forwarded");
    parity_gen_a: assert property (
        (^{i_cm_wr_data, o_cm_wr_parity}) ==
        !st.mode_one[M1_EVEN_PARITY]) else $error("bad write parity");
    irq_masked_a: assert property (
        (st.flags & ~st.mask) == 16'h0000 |-> !o_irq)
        else $error("interrupt from masked flag");
    irq_level_a: assert property (
        i_total_cell_count_wrap && !st.mask[EV_CELL_WRAP] |=> o_irq)
        else $error("unmasked event gave no interrupt");
    masked_sticky_a: assert property (
        i_fault_count_wrap |=> st.flags[EV_FAULT_WRAP] [*1] ##0
        st.flags[EV_FAULT_WRAP])
        else $error("masked event not recorded");
    read_clear_a: assert property (
        i_rd && i_addr == ADDR_EVENT_FLAGS && set == 16'h0000
        |=> o_rdata == $past(st.flags) && st.flags == 16'h0000)
        else $error("flag read did not return and clear");
    wrap_flag_a: assert property (
        i_drop_packet_count_wrap |=> st.flags[EV_PKT_WRAP])
        else $error("packet counter wrap lost");
    reserved_zero_a: assert property (
        !st.flags[EV_RESERVED]) else $error("reserved flag set");
    parity_abort_a: assert property (
        cm_fault |=> st.flags[EV_CM_PARITY] && o_cell_abort)
        else $error("parity fault not handled");
    big_short_a: assert property (
        i_pkt_arrive && !i_pkt_small && i_big_desc_list_vacant
        |=> st.flags[EV_BIG_EXHAUST] && o_pkt_drop)
        else $error("big list exhaustion missed");
    little_short_a: assert property (
        i_pkt_arrive && little_short |=> st.flags[EV_LITTLE_EXHAUST])
        else $error("little list exhaustion missed");
    exc_lost_a: assert property (
        i_exc_report && i_exception_list_at_capacity
        |=> st.flags[EV_EXC_OVERRUN] && !o_exc_write)
        else $error("exception overrun missed");
    done_hold_a: assert property (
        i_pkt_finished && i_done_list_at_capacity |=> o_pkt_hold)
        else $error("finished packet not held");
    cbr_drop_a: assert property (
        i_cbr_cell && i_const_rate_list_at_capacity &&
        !st.mode_zero[M0_CONST_RATE_OVERWRITE]
        |=> o_cbr_drop && st.flags[EV_CONST_OVERRUN])
        else $error("const rate drop missed");
    raw_drop_a: assert property (
        i_raw_cell && i_unprocessed_list_at_capacity &&
        !st.mode_zero[M0_UNPROC_OVERWRITE] |=> o_raw_drop)
        else $error("unprocessed drop missed");
    exc_once_a: assert property (
        $rose(st.flags[EV_EXC_ARRIVED]) |-> $past(i_exception_list_vacant))
        else $error("exception arrival from busy list");
    done_once_a: assert property (
        $rose(st.flags[EV_DONE_ARRIVED]) |-> $past(i_done_list_vacant))
        else $error("done arrival from busy list");
    cbr_once_a: assert property (
        $rose(st.flags[EV_CONST_ARRIVED]) |-> $past(i_const_rate_list_vacant))
        else $error("const arrival from busy list");
    raw_once_a: assert property (
        $rose(st.flags[EV_UNPROC_ARRIVED]) |->
        $past(i_unprocessed_list_vacant))
        else $error("unprocessed arrival from busy list");
    qcond_live_a: assert property (
        i_rd && i_addr == ADDR_QUEUE_COND |=> o_rdata[14:0] ==
        {3'h0, $past(qcond[11:0])}) else $error("queue condition wrong");
    offline_bit_a: assert property (
        o_reassembly_run |-> !qcond[QC_OFF_LINE])
        else $error("off-line bit set while running");
    graceful_a: assert property (
        st.line == ST_DRAIN && i_cycle_busy |=> st.line == ST_DRAIN)
        else $error("went off-line mid cycle");
    overwrite_a: assert property (
        i_cbr_cell && st.mode_zero[M0_CONST_RATE_OVERWRITE]
        |=> o_cbr_write) else $error("overwrite mode dropped cell");
    go_online_c: cover property (
        st.line == ST_OFFLINE ##1 st.line == ST_ONLINE);
    drain_c: cover property (
        st.line == ST_DRAIN && !i_cycle_busy ##1 st.line == ST_OFFLINE);
    read_clear_c: cover property (
        st.flags != 16'h0000 && i_rd && i_addr == ADDR_EVENT_FLAGS);
    irq_c: cover property ($rose(o_irq));
endmodule

/* verification/reassembly_event_status_regs_tb.sv */
`timescale 1ns/1ps
// ======================================
// compare helper, counts every check
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin \
    mismatches++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module reassembly_event_status_regs_tb;
    import reassembly_event_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, wr = 1'b0, rd = 1'b0, busy = 1'b0;
    logic rv = 1'b0, chk = 1'b0, rpar = 1'b0, cc = 1'b0, raw = 1'b0;
    logic cbr = 1'b0, pa = 1'b0, ex = 1'b0, pf = 1'b0, b;
    logic g, ok = 1'b0, sm = 1'b0;
    logic [3:0] addr = 4'h0, wrap = 4'h0, w;
    logic [11:0] q = 12'h000;
    logic [15:0] wd = 16'h0000, cmw = 16'h0000, rdat = 16'h0000, d, t;
    logic [31:0] pmw = 32'h0, seed = 32'hEF5AC91F;
    logic [15:0] rdata;
    logic irq, run, acc, cmp, pmp, abort, cpf, crcf, rw, rdp, cw, cdp;
    logic pdrop, ew, dw, hold;
    int mismatches = 0, comparisons = 0, n;
    reassembly_event_status_regs u_reassembly_event_status_regs (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wd),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq),
        .i_cycle_busy(busy), .o_reassembly_run(run),
        .o_ctrl_mem_access_en(acc), .i_drop_packet_count_wrap(wrap[3]),
        .i_fault_count_wrap(wrap[2]), .i_drop_const_rate_count_wrap(wrap[1]),
        .i_total_cell_count_wrap(wrap[0]), .i_cm_wr_data(cmw),
        .i_pm_wr_data(pmw), .o_cm_wr_parity(cmp), .o_pm_wr_parity(pmp),
        .i_cm_rd_valid(rv), .i_cm_par_chk_en(chk), .i_cm_rd_data(rdat),
        .i_cm_rd_parity(rpar), .o_cell_abort(abort), .i_cell_valid(rv),
        .i_cell_par_chk_en(chk), .i_cell_data(rdat), .i_cell_parity(rpar),
        .o_cell_parity_fault(cpf), .i_cong_cell(cc), .i_cong_crc_ok(ok),
        .o_cong_crc_fault(crcf), .i_raw_cell(raw), .o_raw_write(rw),
        .o_raw_drop(rdp), .i_cbr_cell(cbr), .o_cbr_write(cw),
        .o_cbr_drop(cdp), .i_pkt_arrive(pa), .i_pkt_small(sm),
        .o_pkt_drop(pdrop), .i_exc_report(ex), .o_exc_write(ew),
        .i_pkt_finished(pf), .o_done_write(dw), .o_pkt_hold(hold),
        .i_unprocessed_list_at_capacity(q[11]),
        .i_unprocessed_list_vacant(q[10]),
        .i_const_rate_list_at_capacity(q[9]), .i_const_rate_list_vacant(q[8]),
        .i_exception_list_at_capacity(q[7]), .i_exception_list_vacant(q[6]),
        .i_done_list_at_capacity(q[5]), .i_done_list_vacant(q[4]),
        .i_big_desc_list_at_capacity(q[3]), .i_big_desc_list_vacant(q[2]),
        .i_little_desc_list_at_capacity(q[1]),
        .i_little_desc_list_vacant(q[0]));
    // free-running 50 ns clock
    always #25 i_clk = ~i_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wreg(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk);
        addr <= a; wd <= v; wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rreg(input logic [3:0] a);
        @(posedge i_clk);
        addr <= a; rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // drop all event pulses after one cycle, then look past the edge
    task automatic settle();
        @(posedge i_clk);
        {wrap, rv, cc, raw, cbr, pa, ex, pf} <= '0;
        #1;
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ======================================
    // main sequence
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rreg(ADDR_EVENT_MASK);
        `CHK("mask", EVENT_MASK_RST, d)
        // live queue levels, writes to the read-only word ignored
        repeat (4) begin
            @(posedge i_clk);
            q <= 12'(xs());
            wreg(ADDR_QUEUE_COND, 16'h7FFF);
            rreg(ADDR_QUEUE_COND);
            `CHK("qcond", {4'h8, q}, d)
        end
        // counter wraps while masked: flags stick, no interrupt
        repeat (3) begin
            w = 4'(xs());
            @(posedge i_clk);
            wrap <= w;
            settle();
            `CHK("irq", 1'b0, irq)
            rreg(ADDR_EVENT_FLAGS);
            `CHK("wrap", {w, 12'h000}, d)
            rreg(ADDR_EVENT_FLAGS);
            `CHK("clear", 16'h0000, d)
        end
        wreg(ADDR_EVENT_MASK, 16'h7FFF);
        @(posedge i_clk);
        wrap <= 4'h8;
        settle();
        `CHK("irq", 1'b1, irq)
        rreg(ADDR_EVENT_FLAGS);
        `CHK("irq", 1'b0, irq)
        wreg(ADDR_EVENT_MASK, 16'hFFFF);
        // parity sense and congestion check, good and bad words at random
        for (int k = 0; k < 4; k++) begin
            wreg(ADDR_MODE_ONE, {13'h0, k[1], 1'b0, k[0]});
            b = 1'(xs());
            t = 16'(xs());
            g = 1'(xs());
            @(posedge i_clk);
            cmw <= 16'(xs()); pmw <= xs(); rdat <= t;
            rpar <= (k[0] ? ^t : ~^t) ^ b;
            chk <= 1'b1; rv <= 1'b1; cc <= 1'b1; ok <= g;
            settle();
            `CHK("cmpar", k[0] ? ^cmw : ~^cmw, cmp)
            `CHK("pmpar", k[0] ? ^pmw : ~^pmw, pmp)
            `CHK("cellpar", b, cpf)
            `CHK("abort", b, abort)
            `CHK("crc", k[1] & ~g, crcf)
            `CHK("fwd", 1'b0, rw)
            rreg(ADDR_EVENT_FLAGS);
            `CHK("cmflag", {5'h00, b, 10'h000}, d)
        end
        // full lists: drop, or overwrite when the mode bit allows
        for (int k = 0; k < 2; k++) begin
            wreg(ADDR_MODE_ZERO, {12'h000, k[0], k[0], 2'b00});
            @(posedge i_clk);
            q <= 12'hA00; raw <= 1'b1; cbr <= 1'b1;
            settle();
            `CHK("rawdrop", ~k[0], rdp)
            `CHK("cbrwr", k[0], cw)
            `CHK("rawwr", k[0], rw)
            `CHK("cbrdrop", ~k[0], cdp)
            rreg(ADDR_EVENT_FLAGS);
            `CHK("ovr", {10'h000, ~k[0], ~k[0], 4'h0}, d)
        end
        // large then small packet with no descriptor, report lists full
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            q <= 12'h0A4 | 12'(k); sm <= k[0];
            pa <= 1'b1; ex <= 1'b1; pf <= 1'b1;
            settle();
            `CHK("pktdrop", 1'b1, pdrop)
            `CHK("hold", 1'b1, hold)
            `CHK("excwr", 1'b0, ew)
            rreg(ADDR_EVENT_FLAGS);
            `CHK("full", {7'h01, k[0], 8'hC0}, d)
        end
        @(posedge i_clk);
        q <= 12'h000;
        rreg(ADDR_EVENT_FLAGS);
        `CHK("hold", 1'b0, hold)
        // first entry into each vacant list
        @(posedge i_clk);
        q <= 12'h550; raw <= 1'b1; cbr <= 1'b1; ex <= 1'b1; pf <= 1'b1;
        settle();
        `CHK("excwr", 1'b1, ew)
        `CHK("donewr", 1'b1, dw)
        rreg(ADDR_EVENT_FLAGS);
        `CHK("arrive", 16'h000F, d)
        // on-line, then a graceful exit while a cycle is busy
        wreg(ADDR_MODE_ZERO, 16'h0002);
        @(posedge i_clk);
        #1;
        `CHK("run", 1'b1, run)
        // congestion cell forwarded while on-line
        wreg(ADDR_MODE_ONE, 16'h0002);
        @(posedge i_clk);
        cc <= 1'b1;
        settle();
        `CHK("fwd", 1'b1, rw)
        @(posedge i_clk);
        busy <= 1'b1;
        wreg(ADDR_MODE_ZERO, 16'h0000);
        rreg(ADDR_QUEUE_COND);
        `CHK("drain", 2'b10, {acc, d[15]})
        @(posedge i_clk);
        busy <= 1'b0;
        for (n = 0; n < 20 && d[15] !== 1'b1; n++) rreg(ADDR_QUEUE_COND);
        `CHK("offline", 1'b1, d[15])
        `CHK("offacc", 1'b0, acc)
        stop_test();
    end
endmodule
